/* pkg/acs_regs.svh */
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define ACS_OFF_CTRL    8'h00
`define ACS_OFF_SETLEN  8'h04
`define ACS_OFF_CAPLEN  8'h08
`define ACS_OFF_INSEL   8'h0c
`define ACS_OFF_ANALOG  8'h10
`define ACS_OFF_STATUS  8'h14
`define ACS_OFF_DMISC   8'h18
`define ACS_OFF_DLEFT   8'h1c
`define ACS_OFF_DRIGHT  8'h20
// ****************************************************************
// Field positions
// ****************************************************************
`define ACS_CTRL_EN_LSB   0
`define ACS_CTRL_MAX_LSB  4
`define ACS_CTRL_DIV_LSB  8
`define ACS_CTRL_PD_BIT   16
`define ACS_CAP_LR_LSB    0
`define ACS_CAP_MC_LSB    16
`define ACS_SEL_MISC_LSB  0
`define ACS_SEL_LEFT_LSB  8
`define ACS_SEL_RIGHT_LSB 16
`define ACS_AN_VREF_LSB   0
`define ACS_AN_RES_LSB    8
`define ACS_AN_SCALE_LSB  16
// ****************************************************************
// Reset values
// ****************************************************************
`define ACS_CTRL_RST    32'h0001_0000
`define ACS_SETLEN_RST  32'h0000_000a
`define ACS_CAPLEN_RST  32'h0082_00aa
`define ACS_INSEL_RST   32'h0000_0000
`define ACS_ANALOG_RST  32'h0000_0000
// ****************************************************************
// Usage-case settings and constants
// ****************************************************************
`define ACS_MASK_MISC   4'h4
`define ACS_MAX_MISC    3'h2
`define ACS_MASK_RNG    4'h8
`define ACS_MAX_RNG     3'h0
`define ACS_MASK_LRM    4'h7
`define ACS_MAX_LRM     3'h6
`define ACS_VREF_0_MV   12'h258
`define ACS_VREF_1_MV   12'h384
`define ACS_VREF_2_MV   12'h4b0
`define ACS_VREF_BAT_MV 12'h000
`define ACS_RESP_OKAY   2'h0
`define ACS_RESP_SLVERR 2'h2
`endif

/* pkg/acs_pkg.sv */
package acs_pkg;
  typedef enum logic [1:0] {acs_st_idle, acs_st_set, acs_st_capt} acs_state_t;
  typedef enum logic [1:0] {acs_ch_left, acs_ch_right, acs_ch_misc, acs_ch_rng} acs_chan_t;
endpackage

/* rtl/acs_clkdiv.sv */
`timescale 1ns/1ns
`include "acs_regs.svh"
module acs_clkdiv (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [2:0] div,
  output logic            tick
);
  logic [2:0] cnt_reg;
  logic       tick_reg;
  logic [3:0] gap_reg;
  logic       clean_reg;

  assign tick = tick_reg;

  // Tick once every div+1 cycles
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_reg  <= 3'h0;
      tick_reg <= 1'b0;
    end
    else if (ce)
    begin
      tick_reg <= run && (cnt_reg >= div); // RQ4
      cnt_reg  <= (!run || cnt_reg >= div) ? 3'h0 : cnt_reg + 3'h1; // RQ4
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gap_reg   <= 4'h0;
      clean_reg <= 1'b0;
    end
    else if (ce)
    begin
      gap_reg   <= tick_reg ? 4'h1 : gap_reg + 4'h1;
      clean_reg <= run && $stable(div) && (clean_reg || tick_reg);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  div_period_a: assert property (ce && tick_reg && clean_reg && run
    |-> gap_reg == {1'b0, $past(div)} + 4'h1) // RQ4
    else $error("adc clock tick spacing differs from divider plus one");
  div_stop_a: assert property (!run && ce |=> !tick_reg)
    else $error("adc clock tick while powered down");
endmodule // acs_clkdiv

/* rtl/acs_capture.sv */
`timescale 1ns/1ns
module acs_capture (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic              strobe,
  input  acs_pkg::acs_chan_t     chan,
  input  wire logic [1:0]        res,
  input  wire logic [14:0]       raw,
  output logic      [14:0]       q_left,
  output logic      [14:0]       q_right,
  output logic      [14:0]       q_misc
);
  logic [14:0] mem_reg [0:2];

  // Keep res-selected valid bits and sign-extend to 15 bits
  function automatic logic [14:0] sext(input logic [14:0] d, input logic [1:0] r);
    logic [3:0] sb;
    logic [14:0] o;
    sb = 4'h7 + {1'b0, r, 1'b0};
    o = d;
    for (int i = 0; i < 15; i++)
      if (4'(i) > sb)
        o[i] = d[sb];
    return o;
  endfunction

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 3; i++)
        mem_reg[i] <= 15'h0000;
    end
    else if (ce && strobe && chan != acs_pkg::acs_ch_rng)
      mem_reg[chan] <= sext(raw, res); // RQ10 RQ11
  end

  assign q_left  = mem_reg[0];
  assign q_right = mem_reg[1];
  assign q_misc  = mem_reg[2];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sign_ext_a: assert property (ce && strobe && chan == acs_pkg::acs_ch_misc && res == 2'h3
                               |=> q_misc == {$past(raw[13]), $past(raw[13:0])}) // RQ10
    else $error("fourteen bit result not sign extended");
  sign_ext10_a: assert property (ce && strobe && chan == acs_pkg::acs_ch_left && res == 2'h1
                                 |=> q_left[14:9] == {6{$past(raw[9])}}) // RQ10
    else $error("ten bit result not sign extended");
endmodule // acs_capture

/* rtl/acs_seq.sv */
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "acs_regs.svh"
// Summary of operation
// (RQ1) Mask 0x4 with maximum index 2 runs one Set and one misc Capture per frame.
// (RQ2) Mask 0x8 with maximum index 0 runs a single random-number Capture per frame.
// (RQ3) Mask 0x7 with maximum index 6 runs Set/Capture for left, then right, then misc.
// (RQ4) The ADC clock ticks once every divider plus one source cycles.
// (RQ5) Left input select holds positive code in the upper nibble, negative in the lower.
// (RQ6) Right input select uses the same nibble layout.
// (RQ7) Misc select 0xa0 gives pin C5 positive and no negative input, i.e. single-ended.
// (RQ8) A channel with a negative input is differential, otherwise single-ended.
// (RQ9) Reference code 0,1,2 give 0.6, 0.9, 1.2 V; code 3 is a battery fraction.
// (RQ10) Resolution codes 0..3 give 8/10/12/14 valid bits in a sign-extended 15-bit word.
// (RQ11) Each Capture state other than RNG starts a conversion at its start and captures data at its end.
// (RQ12) Indices step from the first enabled state to the maximum and wrap with no idle.
module acs_seq (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [14:0] adc_data_in,
  output logic             adc_pd,
  output logic             adc_clk_en,
  output logic             adc_run,
  output logic             adc_capture,
  output logic [3:0]       adc_pos_sel,
  output logic [3:0]       adc_neg_sel,
  output logic             adc_single_ended,
  output logic [1:0]       adc_vref_sel,
  output logic [11:0]      adc_vref_mv,
  output logic [1:0]       adc_res_sel,
  output logic [1:0]       adc_scale_sel,
  output logic [2:0]       seq_index
);
  // ****************************************************************
  // Registers and bus state
  // ****************************************************************
  logic [31:0] ctrl_reg, setlen_reg, caplen_reg, insel_reg, analog_reg;
  logic        aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg, vld_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0]  wstrb_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  acs_pkg::acs_state_t state_reg;
  acs_pkg::acs_chan_t  chan_reg, enter_chan, chan_next;
  logic [2:0]  idx_reg, first_idx, enter_idx;
  logic [9:0]  cnt_reg, enter_len;
  logic        end_st, entering, enter_set, cap_strobe, run_reg, capture_reg, do_write;
  logic [3:0]  en;
  logic [2:0]  max_idx;
  logic [14:0] q_left, q_right, q_misc;
  logic [3:0]  pos_reg, neg_reg;
  logic [1:0]  vref_reg, res_reg;
  logic [11:0] mv_reg;

  assign en      = ctrl_reg[`ACS_CTRL_EN_LSB +: 4];
  assign max_idx = ctrl_reg[`ACS_CTRL_MAX_LSB +: 3];
  assign adc_pd  = ctrl_reg[`ACS_CTRL_PD_BIT];

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (s[i])
        r[8*i +: 8] = d[8*i +: 8];
    return r;
  endfunction

  // Channel that owns state index i: index 0 is RNG, pairs 1-2, 3-4, 5-6 go to
  // the enabled channels among left, right, misc in that order
  function automatic acs_pkg::acs_chan_t chan_at(input logic [3:0] m, input logic [2:0] i);
    logic [1:0] k;
    logic [1:0] n;
    acs_pkg::acs_chan_t c;
    k = 2'((4'(i) + 4'h1) >> 1);
    n = 2'h0;
    c = acs_pkg::acs_ch_misc;
    if (i == 3'h0)
      c = acs_pkg::acs_ch_rng;
    else
      for (int b = 0; b < 3; b++)
        if (m[b])
        begin
          n = n + 2'h1;
          if (n == k)
            c = acs_pkg::acs_chan_t'(2'(b));
        end
    return c;
  endfunction

  function automatic logic [1:0] pick2(input logic [31:0] w, input int b,
                                       input acs_pkg::acs_chan_t c);
    return w[b + 2 * int'(c) +: 2];
  endfunction

  function automatic logic [7:0] sel_of(input acs_pkg::acs_chan_t c);
    case (c)
      acs_pkg::acs_ch_left:  sel_of = insel_reg[`ACS_SEL_LEFT_LSB +: 8];
      acs_pkg::acs_ch_right: sel_of = insel_reg[`ACS_SEL_RIGHT_LSB +: 8];
      acs_pkg::acs_ch_misc:  sel_of = insel_reg[`ACS_SEL_MISC_LSB +: 8];
      default:               sel_of = 8'h00;
    endcase
  endfunction

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  assign awready  = !aw_full_reg && !bvalid_reg;
  assign wready   = !w_full_reg && !bvalid_reg;
  assign arready  = !rvalid_reg;
  assign bvalid   = bvalid_reg;
  assign bresp    = bresp_reg;
  assign rvalid   = rvalid_reg;
  assign rdata    = rdata_reg;
  assign rresp    = rresp_reg;
  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `ACS_RESP_OKAY;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        aw_full_reg <= 1'b1;
        awaddr_reg  <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_full_reg <= 1'b1;
        wdata_reg  <= wdata;
        wstrb_reg  <= wstrb;
      end
      if (do_write)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= (awaddr_reg <= `ACS_OFF_ANALOG && awaddr_reg[1:0] == 2'h0)
                       ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
      end
      else if (bready)
        bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg   <= `ACS_CTRL_RST;
      setlen_reg <= `ACS_SETLEN_RST;
      caplen_reg <= `ACS_CAPLEN_RST;
      insel_reg  <= `ACS_INSEL_RST;
      analog_reg <= `ACS_ANALOG_RST;
    end
    else if (ce && do_write)
    begin
      case (awaddr_reg)
        `ACS_OFF_CTRL:   ctrl_reg   <= merge(ctrl_reg, wdata_reg, wstrb_reg) & 32'h0001_077f;
        `ACS_OFF_SETLEN: setlen_reg <= merge(setlen_reg, wdata_reg, wstrb_reg) & 32'h0000_00ff;
        `ACS_OFF_CAPLEN: caplen_reg <= merge(caplen_reg, wdata_reg, wstrb_reg) & 32'h03ff_03ff;
        `ACS_OFF_INSEL:  insel_reg  <= merge(insel_reg, wdata_reg, wstrb_reg) & 32'h00ff_ffff;
        `ACS_OFF_ANALOG: analog_reg <= merge(analog_reg, wdata_reg, wstrb_reg) & 32'h0003_3f3f;
        default:         ;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `ACS_RESP_OKAY;
    end
    else if (ce)
    begin
      if (arvalid && arready)
      begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= `ACS_RESP_OKAY;
        case (araddr)
          `ACS_OFF_CTRL:   rdata_reg <= ctrl_reg;
          `ACS_OFF_SETLEN: rdata_reg <= setlen_reg;
          `ACS_OFF_CAPLEN: rdata_reg <= caplen_reg;
          `ACS_OFF_INSEL:  rdata_reg <= insel_reg;
          `ACS_OFF_ANALOG: rdata_reg <= analog_reg;
          `ACS_OFF_STATUS: rdata_reg <= {23'h0, vld_reg, 2'h0, chan_reg,
                                         state_reg != acs_pkg::acs_st_idle, idx_reg};
          `ACS_OFF_DMISC:  rdata_reg <= {17'h0, q_misc};
          `ACS_OFF_DLEFT:  rdata_reg <= {17'h0, q_left};
          `ACS_OFF_DRIGHT: rdata_reg <= {17'h0, q_right};
          default:
          begin
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `ACS_RESP_SLVERR;
          end
        endcase
      end
      else if (rready)
        rvalid_reg <= 1'b0;
    end
  end

  // Data-valid flag: set by a capture, cleared by a status read; set wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      vld_reg <= 1'b0;
    else if (ce)
      vld_reg <= cap_strobe || (vld_reg && !(arvalid && arready && araddr == `ACS_OFF_STATUS));
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  assign first_idx  = en[3] ? 3'h0 : 3'h1;
  assign end_st     = state_reg != acs_pkg::acs_st_idle && cnt_reg == 10'h000;
  assign entering   = (|en) && (state_reg == acs_pkg::acs_st_idle || end_st);
  assign enter_idx  = (state_reg == acs_pkg::acs_st_idle || idx_reg >= max_idx)
                      ? first_idx : idx_reg + 3'h1; // RQ12
  assign enter_chan = chan_at(en, enter_idx); // RQ1 RQ2 RQ3
  assign enter_set  = enter_idx[0];
  assign enter_len  = enter_set ? {2'h0, setlen_reg[7:0]}
                    : (enter_chan == acs_pkg::acs_ch_misc || enter_chan == acs_pkg::acs_ch_rng)
                    ? caplen_reg[`ACS_CAP_MC_LSB +: 10] : caplen_reg[`ACS_CAP_LR_LSB +: 10];
  assign cap_strobe = end_st && state_reg == acs_pkg::acs_st_capt
                      && chan_reg != acs_pkg::acs_ch_rng; // RQ11
  assign chan_next  = entering ? enter_chan : chan_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= acs_pkg::acs_st_idle;
      idx_reg   <= 3'h0;
      cnt_reg   <= 10'h000;
      chan_reg  <= acs_pkg::acs_ch_misc;
    end
    else if (ce)
    begin
      case (state_reg)
        acs_pkg::acs_st_idle, acs_pkg::acs_st_set, acs_pkg::acs_st_capt:
        begin
          if (entering)
          begin
            state_reg <= enter_set ? acs_pkg::acs_st_set : acs_pkg::acs_st_capt;
            idx_reg   <= enter_idx;
            chan_reg  <= enter_chan;
            cnt_reg   <= (enter_len == 10'h000) ? 10'h000 : enter_len - 10'h001;
          end
          else if (end_st)
            state_reg <= acs_pkg::acs_st_idle;
          else if (state_reg != acs_pkg::acs_st_idle)
            cnt_reg <= cnt_reg - 10'h001;
        end
        default: state_reg <= acs_pkg::acs_st_idle;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_reg     <= 1'b0;
      capture_reg <= 1'b0;
    end
    else if (ce)
    begin
      run_reg     <= entering && !enter_set && enter_chan != acs_pkg::acs_ch_rng; // RQ11
      capture_reg <= cap_strobe; // RQ11
    end
  end

  // Analog settings follow the channel that owns the coming state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pos_reg  <= 4'h0;
      neg_reg  <= 4'h0;
      vref_reg <= 2'h0;
      res_reg  <= 2'h0;
      mv_reg   <= `ACS_VREF_0_MV;
    end
    else if (ce)
    begin
      {pos_reg, neg_reg} <= sel_of(chan_next); // RQ5 RQ6 RQ7
      vref_reg <= pick2(analog_reg, `ACS_AN_VREF_LSB, chan_next);
      res_reg  <= pick2(analog_reg, `ACS_AN_RES_LSB, chan_next);
      case (pick2(analog_reg, `ACS_AN_VREF_LSB, chan_next))
        2'h0:    mv_reg <= `ACS_VREF_0_MV; // RQ9
        2'h1:    mv_reg <= `ACS_VREF_1_MV; // RQ9
        2'h2:    mv_reg <= `ACS_VREF_2_MV; // RQ9
        default: mv_reg <= `ACS_VREF_BAT_MV;
      endcase
    end
  end

  assign adc_pos_sel      = pos_reg;
  assign adc_neg_sel      = neg_reg;
  assign adc_single_ended = neg_reg == 4'h0; // RQ7 RQ8
  assign adc_vref_sel     = vref_reg;
  assign adc_vref_mv      = mv_reg;
  assign adc_res_sel      = res_reg;
  assign adc_scale_sel    = analog_reg[`ACS_AN_SCALE_LSB +: 2];
  assign adc_run          = run_reg;
  assign adc_capture      = capture_reg;
  assign seq_index        = idx_reg;

  acs_clkdiv u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .run     (!adc_pd),
    .div     (ctrl_reg[`ACS_CTRL_DIV_LSB +: 3]),
    .tick    (adc_clk_en)
  );

  acs_capture u_cap (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .strobe  (cap_strobe),
    .chan    (chan_reg),
    .res     (pick2(analog_reg, `ACS_AN_RES_LSB, chan_reg)),
    .raw     (adc_data_in),
    .q_left  (q_left),
    .q_right (q_right),
    .q_misc  (q_misc)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  misc_case_a: assert property (ce && end_st && en == `ACS_MASK_MISC && max_idx == `ACS_MAX_MISC
    |=> idx_reg == ($past(idx_reg) == 3'h1 ? 3'h2 : 3'h1)
    && chan_reg == acs_pkg::acs_ch_misc) // RQ1
    else $error("misc-only frame does not alternate Set and Capture");
  rng_case_a: assert property (ce && end_st && en == `ACS_MASK_RNG && max_idx == `ACS_MAX_RNG
    |=> idx_reg == 3'h0 && state_reg == acs_pkg::acs_st_capt && chan_reg == acs_pkg::acs_ch_rng) // RQ2
    else $error("rng-only frame is not a single capture");
  lrm_order_a: assert property (ce && end_st && en == `ACS_MASK_LRM && max_idx == `ACS_MAX_LRM
    && idx_reg == 3'h2 |=> idx_reg == 3'h3 && chan_reg == acs_pkg::acs_ch_right) // RQ3
    else $error("right channel does not follow left");
  frame_wrap_a: assert property (ce && end_st && (|en) && idx_reg >= max_idx
    |=> idx_reg == $past(first_idx)) // RQ12
    else $error("frame did not wrap to the first state");
  no_idle_a: assert property (ce && state_reg != acs_pkg::acs_st_idle && (|en)
    |=> state_reg != acs_pkg::acs_st_idle) // RQ12
    else $error("idle cycle inside running sequence");
  run_start_a: assert property (ce && entering && !enter_set && enter_chan != acs_pkg::acs_ch_rng
    |=> adc_run && state_reg == acs_pkg::acs_st_capt) // RQ11
    else $error("conversion start missing at capture start");
  cap_end_a: assert property (adc_capture |-> $past(state_reg) == acs_pkg::acs_st_capt
    && $past(cnt_reg) == 10'h000) // RQ11
    else $error("capture pulse not at capture end");
  left_sel_a: assert property (ce && chan_next == acs_pkg::acs_ch_left
    |=> {adc_pos_sel, adc_neg_sel} == $past(insel_reg[`ACS_SEL_LEFT_LSB +: 8])) // RQ5
    else $error("left select nibbles misplaced");
  right_sel_a: assert property (ce && chan_next == acs_pkg::acs_ch_right
    |=> {adc_pos_sel, adc_neg_sel} == $past(insel_reg[`ACS_SEL_RIGHT_LSB +: 8])) // RQ6
    else $error("right select nibbles misplaced");
  misc_single_a: assert property (ce && chan_next == acs_pkg::acs_ch_misc
    && insel_reg[7:0] == 8'ha0 |=> adc_pos_sel == 4'ha && adc_single_ended) // RQ7 RQ8
    else $error("misc select 0xa0 not single-ended on C5");
  vref_map_a: assert property (ce && pick2(analog_reg, 0, chan_next) == 2'h1
    |=> adc_vref_mv == `ACS_VREF_1_MV && adc_vref_sel == 2'h1) // RQ9
    else $error("reference code 1 not 0.9 V");

  misc_frame_c: cover property (en == `ACS_MASK_MISC && max_idx == `ACS_MAX_MISC && cap_strobe);
  rng_frame_c:  cover property (en == `ACS_MASK_RNG && end_st && state_reg == acs_pkg::acs_st_capt);
  lrm_frame_c:  cover property (en == `ACS_MASK_LRM && end_st && idx_reg == 3'h6);
  axi_both_c:   cover property (awvalid && awready && wvalid && wready);
endmodule // acs_seq

/* bench/tb.sv */
`timescale 1ns/1ns
`include "acs_regs.svh"
// *********************************
// Sequencer bench
// *********************************
module tb;
  typedef struct {logic [2:0] idx; int cyc; logic [22:0] an;} acs_ent_t;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0]  wstrb = 0, pos, neg;
  logic [14:0] raw = 0;
  logic [1:0]  bresp, rresp, vsel, res, scl, rsp;
  logic [11:0] mv;
  logic [2:0]  idx, last = 0;
  logic        awready, wready, bvalid, arready, rvalid, pd, cen, run, cap, se;
  int          errors = 0, cmp_count = 0, cyc = 0, stay = 0, runs = 0, caps = 0;
  int          n, r0, c0;
  int          dv[4] = '{5, 0, 7, 0};
  acs_ent_t    q[$];

  acs_seq dut (.aclk(aclk), .aresetn(aresetn), .ce(1'h1), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .adc_data_in(raw), .adc_pd(pd), .adc_clk_en(cen),
    .adc_run(run), .adc_capture(cap), .adc_pos_sel(pos), .adc_neg_sel(neg),
    .adc_single_ended(se), .adc_vref_sel(vsel), .adc_vref_mv(mv), .adc_res_sel(res),
    .adc_scale_sel(scl), .seq_index(idx));

  always #50 aclk = ~aclk;

  // Logs each state on its second cycle
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    runs <= runs + run;
    caps <= caps + cap;
    if (idx !== last)
    begin
      last <= idx;
      stay <= 0;
    end
    else
    begin
      stay <= stay + 1;
      if (stay == 0)
        q.push_back('{idx, cyc, {pos, neg, se, mv, res}});
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 0;
      if (wvalid && wready)
        wvalid <= 0;
    end
    while (bvalid !== 1'h1);
    rsp = bresp;
    bready <= 0;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 0;
    end
    while (rvalid !== 1'h1);
    d = rdata;
    rsp = rresp;
    rready <= 0;
  endtask

  function automatic logic [31:0] ext(input logic [14:0] v, input int r);
    for (int i = 8 + 2 * r; i < 15; i++)
      v[i] = v[7 + 2 * r];
    return {17'h0, v};
  endfunction

  function automatic logic [22:0] an_of(input int i, input int mi);
    if (i == mi)
      return {4'ha, 4'h0, 1'h1, `ACS_VREF_2_MV, 2'h3};
    return i == 2 ? {4'h1, 4'h2, 1'h0, `ACS_VREF_0_MV, 2'h1}
                  : {4'h3, 4'h4, 1'h0, `ACS_VREF_1_MV, 2'h2};
  endfunction

  task automatic run_seq(input logic [3:0] m, input logic [2:0] mx, input int mi,
                         input int nc, input int fr);
    axw(`ACS_OFF_CTRL, {24'h0, 1'h0, mx, m});
    repeat (60) @(posedge aclk);
    q = {};
    r0 = runs;
    c0 = caps;
    repeat (2 * fr) @(posedge aclk);
    chk(runs - r0, 2 * nc);
    chk(caps - c0, 2 * nc);
    chk(q.size() > 3, 1);
    foreach (q[k])
      if (k > 0)
      begin
        chk(q[k].idx, q[k-1].idx >= mx ? 1 : q[k-1].idx + 1);
        chk(q[k].cyc - q[k-1].cyc, q[k-1].idx[0] ? 3 : q[k-1].idx == mi ? 5 : 4);
        if (!q[k].idx[0])
          chk(q[k].an, an_of(q[k].idx, mi));
      end
  endtask

  task automatic end_sim;
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    void'($urandom(95));
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    axr(`ACS_OFF_CTRL);
    chk(d, `ACS_CTRL_RST);
    axr(`ACS_OFF_CAPLEN);
    chk(d, `ACS_CAPLEN_RST);
    axr(8'h40);
    chk(rsp, `ACS_RESP_SLVERR);
    chk(d, 32'h0);
    axw(`ACS_OFF_STATUS, 32'h1);
    chk(rsp, `ACS_RESP_SLVERR);
    $display("test regs done");
    dv[3] = $urandom % 8;
    foreach (dv[k])
    begin
      axw(`ACS_OFF_CTRL, dv[k] << 8);
      repeat (2)
      begin
        @(posedge aclk);
        while (cen !== 1'h1) @(posedge aclk);
      end
      n = 0;
      do
      begin
        @(posedge aclk);
        n++;
      end
      while (cen !== 1'h1);
      chk(n, dv[k] + 1);
    end
    chk(pd, 0);
    $display("test div done");
    raw <= 15'($urandom);
    axw(`ACS_OFF_SETLEN, 32'h3);
    axw(`ACS_OFF_CAPLEN, 32'h0005_0004);
    axw(`ACS_OFF_INSEL, 32'h0034_12a0);
    axw(`ACS_OFF_ANALOG, 32'h0000_3924);
    run_seq(`ACS_MASK_LRM, `ACS_MAX_LRM, 6, 3, 22);
    axr(`ACS_OFF_DLEFT);
    chk(d, ext(raw, 1));
    axr(`ACS_OFF_DRIGHT);
    chk(d, ext(raw, 2));
    axr(`ACS_OFF_DMISC);
    chk(d, ext(raw, 3));
    axr(`ACS_OFF_STATUS);
    chk(d[8], 1);
    $display("test lrm done");
    run_seq(`ACS_MASK_MISC, `ACS_MAX_MISC, 2, 1, 8);
    $display("test misc done");
    axw(`ACS_OFF_CTRL, {28'h0, `ACS_MASK_RNG});
    repeat (60) @(posedge aclk);
    r0 = runs;
    repeat (40)
    begin
      @(posedge aclk);
      chk(idx, `ACS_MAX_RNG);
    end
    chk(runs - r0, 0);
    $display("test rng done");
    end_sim;
  end

  initial
  begin
    #(100 * 20000);
    errors++;
    end_sim;
  end
endmodule // tb
